// [eeprom_cmd_pkg.sv]
// shared constants and types for the serial nonvolatile memory command port
package eeprom_cmd_pkg;

	// ************************************************************
	// instruction encoding
	// ************************************************************
	localparam logic [1:0] OP_SPECIAL    = 2'h0; // program enable/disable, clear-all, write-all
	localparam logic [1:0] OP_WRITE      = 2'h1; // write one location
	localparam logic [1:0] OP_READ       = 2'h2; // read, sequential
	localparam logic [1:0] OP_ERASE      = 2'h3; // clear one location
	localparam logic [1:0] SUB_DISABLE   = 2'h0; // program_disable_cmd
	localparam logic [1:0] SUB_WRITE_ALL = 2'h1; // write_all_cmd
	localparam logic [1:0] SUB_CLEAR_ALL = 2'h2; // clear_all_cmd
	localparam logic [1:0] SUB_ENABLE    = 2'h3; // program_enable_cmd

	// ************************************************************
	// organization and array
	// ************************************************************
	localparam int         OPCODE_BITS    = 2;     // opcode after the start bit
	localparam int         ADDR_BITS_X8   = 11;    // address field, byte organization
	localparam int         ADDR_BITS_X16  = 10;    // address field, word organization
	localparam int         DATA_BITS_X8   = 8;     // data field, byte organization
	localparam int         DATA_BITS_X16  = 16;    // data field, word organization
	localparam int         MEM_BYTES      = 1024;  // 8192 bits of array
	localparam int         BYTE_ADDR_BITS = 10;    // byte index width
	localparam logic [7:0] ERASED_BYTE    = 8'hFF; // cleared cells read as ones
	localparam logic       ORG_RESET      = 1'h1;  // wide organization until strap seen

	// ************************************************************
	// timing
	// ************************************************************
	localparam int  CLK_PERIOD_NS          = 10;   // core clock period
	localparam int  PROGRAM_CYCLE_TIME_MS  = 5;    // program_cycle_time, longest
	localparam int  PROGRAM_CYCLES         =       // longest time rounds down
		(PROGRAM_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS;
	localparam real SELECT_LOW_GAP_US      = 0.25; // select_low_gap, host side
	localparam int  POWERUP_READ_WAIT_MS   = 1;    // powerup_read_wait, host side
	localparam int  POWERUP_WRITE_WAIT_MS  = 1;    // powerup_write_wait, host side
	localparam int  SERIAL_CLOCK_LIMIT_KHZ = 2000; // serial_clock_limit, host side

	// ************************************************************
	// link state machine
	// ************************************************************
	typedef enum logic [1:0] {
		L_IDLE  = 2'b00, // waiting for a start bit
		L_SHIFT = 2'b01, // taking opcode, address, data
		L_READ  = 2'b10, // shifting read data out
		L_DONE  = 2'b11  // instruction complete, waiting for deselect
	} link_state_t;

endpackage : eeprom_cmd_pkg

// [level_sync.sv]
// two flip-flop synchroniser for slow levels crossing into a clock domain
`timescale 1ns/1ps

module level_sync #(
	parameter int W = 1 // number of independent levels
) (
	input  wire logic         clk,   // destination clock
	input  wire logic         clear, // asynchronous clear to zero
	input  wire logic [W-1:0] d,     // level from the other domain
	output logic      [W-1:0] q      // synchronised level
);

	logic [W-1:0] meta_r; // first stage, read only by the second stage

	// ************************************************************
	// two stages; the first may go metastable and feeds nothing else
	// ************************************************************
	always_ff @(posedge clk or posedge clear) begin
		if (clear) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : level_sync

// [eeprom_cmd_port.sv]
// serial nonvolatile memory command port: link decoder, array and program timer
`timescale 1ns/1ps

module eeprom_cmd_port #(
	parameter int PROG_CYCLES = eeprom_cmd_pkg::PROGRAM_CYCLES // program cycle length
) (
	input  wire logic clk,              // core clock, 100 MHz
	input  wire logic reset,            // active high; synchronous for core registers, asynchronous clear for link and command registers
	input  wire logic serial_clock_in,  // link clock from the host
	input  wire logic serial_select_in, // device select, high active
	input  wire logic serial_data_in,   // instruction, address and data bits
	input  wire logic org_strap_in,     // organization strap, high = word wide
	output logic      serial_data_out,  // read data or ready/busy status
	output logic      serial_data_oe    // high while the output is driven
);

	localparam int CW = $clog2(PROG_CYCLES + 1); // program counter width

	// the sweep through the array must fit in the program cycle
	if (PROG_CYCLES <= eeprom_cmd_pkg::MEM_BYTES) begin : g_bad_cycles
		$error("PROG_CYCLES too small for the array sweep");
	end

	// ************************************************************
	// array and its read view
	// ************************************************************
	logic [7:0] mem_r [eeprom_cmd_pkg::MEM_BYTES]; // array bytes, written in core domain

	// one location, msb aligned to bit 15; byte locations sit in the upper half
	function automatic logic [15:0] loc_word(input logic [9:0] a, input logic wide);
		if (wide) begin
			loc_word = {mem_r[{a[8:0], 1'b0}], mem_r[{a[8:0], 1'b1}]};
		end else begin
			loc_word = {mem_r[a], 8'h00};
		end
	endfunction : loc_word

	// ************************************************************
	// link domain: frame state, cleared whenever select is low
	// ************************************************************
	logic                       frame_clr;                 // deselect or core reset
	eeprom_cmd_pkg::link_state_t lst_r, lst_nxt;           // link state
	logic [4:0]                 bcnt_r, bcnt_nxt;          // bits after the start bit
	logic [9:0]                 rd_addr_r, rd_addr_nxt;    // location being read
	logic [15:0]                rd_sh_r, rd_sh_nxt;        // outgoing read bits
	logic [4:0]                 rd_left_r, rd_left_nxt;    // bits left in this word
	logic                       rd_bit_r, rd_bit_nxt;      // current output bit
	logic                       rd_act_r, rd_act_nxt;      // read output active
	logic                       lk_act_r, lk_act_nxt;      // start bit taken this frame
	logic                       busy_lk, org_lk;           // core levels seen on link clock
	logic [1:0]                 op_r, op_nxt;              // command opcode
	logic [10:0]                addr_r, addr_nxt;          // command address field
	logic [15:0]                data_r, data_nxt;          // command data field
	logic                       armed_r, armed_nxt;        // complete command waiting
	logic [15:0]                nxt_word;                  // next location in a sequential read
	logic [4:0]                 hdr_n, tot_n, n;           // field boundaries
	logic [1:0]                 sub;                       // address top two bits
	logic [9:0]                 eff_addr;                  // address without don't-care bit
	logic                       busy_r, org_r;             // core domain state

	assign frame_clr = ~serial_select_in | reset;

	level_sync #(.W(2)) u_sync_lk (
		.clk   (serial_clock_in),
		.clear (reset),
		.d     ({busy_r, org_r}),
		.q     ({busy_lk, org_lk})
	);

	// ************************************************************
	// link next state: one bit per rising serial clock edge
	// ************************************************************
	always_comb begin
		lst_nxt     = lst_r;
		bcnt_nxt    = bcnt_r;
		rd_addr_nxt = rd_addr_r;
		rd_sh_nxt   = rd_sh_r;
		rd_left_nxt = rd_left_r;
		rd_bit_nxt  = rd_bit_r;
		rd_act_nxt  = rd_act_r;
		lk_act_nxt  = lk_act_r;
		op_nxt      = op_r;
		addr_nxt    = addr_r;
		data_nxt    = data_r;
		armed_nxt   = armed_r;
		nxt_word    = 16'h0000;
		n           = bcnt_r + 5'd1;
		hdr_n       = org_lk ? 5'(eeprom_cmd_pkg::OPCODE_BITS + eeprom_cmd_pkg::ADDR_BITS_X16)
		                     : 5'(eeprom_cmd_pkg::OPCODE_BITS + eeprom_cmd_pkg::ADDR_BITS_X8);
		tot_n       = hdr_n + (org_lk ? 5'(eeprom_cmd_pkg::DATA_BITS_X16)
		                              : 5'(eeprom_cmd_pkg::DATA_BITS_X8));
		sub         = org_lk ? addr_r[8:7] : addr_r[9:8]; // top bits after this edge's shift
		eff_addr    = org_lk ? {1'b0, addr_r[7:0], serial_data_in}
		                     : {addr_r[8:0], serial_data_in}; // top bit dropped
		unique case (lst_r)
			eeprom_cmd_pkg::L_IDLE: begin
				// zeros are skipped; starts are refused while programming
				if (serial_data_in && !busy_lk) begin
					lst_nxt    = eeprom_cmd_pkg::L_SHIFT;
					bcnt_nxt   = 5'd0;
					lk_act_nxt = 1'b1;
					armed_nxt  = 1'b0;
				end
			end
			eeprom_cmd_pkg::L_SHIFT: begin
				bcnt_nxt = n; // sampled on the rising edge
				if (n <= 5'(eeprom_cmd_pkg::OPCODE_BITS)) begin
					op_nxt = {op_r[0], serial_data_in};
				end else if (n <= hdr_n) begin
					addr_nxt = {addr_r[9:0], serial_data_in};
				end else begin
					data_nxt = {data_r[14:0], serial_data_in};
				end
				if (n == hdr_n) begin
					if (op_r == eeprom_cmd_pkg::OP_READ) begin
						// first output bit is the dummy zero
						lst_nxt     = eeprom_cmd_pkg::L_READ;
						rd_addr_nxt = eff_addr;
						rd_sh_nxt   = loc_word(eff_addr, org_lk);
						rd_left_nxt = org_lk ? 5'(eeprom_cmd_pkg::DATA_BITS_X16)
						                     : 5'(eeprom_cmd_pkg::DATA_BITS_X8);
						rd_bit_nxt  = 1'b0;
						rd_act_nxt  = 1'b1;
					end else if (op_r == eeprom_cmd_pkg::OP_WRITE ||
					             (op_r == eeprom_cmd_pkg::OP_SPECIAL &&
					              sub == eeprom_cmd_pkg::SUB_WRITE_ALL)) begin
						lst_nxt = eeprom_cmd_pkg::L_SHIFT; // data field follows
					end else begin
						lst_nxt   = eeprom_cmd_pkg::L_DONE;
						armed_nxt = 1'b1;
					end
				end else if (n == tot_n) begin
					lst_nxt   = eeprom_cmd_pkg::L_DONE;
					armed_nxt = 1'b1;
				end
			end
			eeprom_cmd_pkg::L_READ: begin
				if (rd_left_r == 5'd0) begin
					// next location, wrapping at the top, no dummy bit
					rd_addr_nxt = org_lk ? {1'b0, rd_addr_r[8:0] + 9'd1} : rd_addr_r + 10'd1;
					nxt_word    = loc_word(rd_addr_nxt, org_lk);
					rd_sh_nxt   = {nxt_word[14:0], 1'b0};
					rd_bit_nxt  = nxt_word[15]; // msb goes out straight away
					rd_left_nxt = (org_lk ? 5'(eeprom_cmd_pkg::DATA_BITS_X16)
					                      : 5'(eeprom_cmd_pkg::DATA_BITS_X8)) - 5'd1;
				end else begin
					rd_bit_nxt  = rd_sh_r[15]; // msb first
					rd_sh_nxt   = {rd_sh_r[14:0], 1'b0};
					rd_left_nxt = rd_left_r - 5'd1;
				end
			end
			eeprom_cmd_pkg::L_DONE: begin
				// a clock edge before deselect spoils the command
				armed_nxt = 1'b0;
			end
		endcase
	end

	// frame registers; deselect clears them since the serial clock may stop
	always_ff @(posedge serial_clock_in or posedge frame_clr) begin
		if (frame_clr) begin
			lst_r     <= eeprom_cmd_pkg::L_IDLE;
			bcnt_r    <= 5'h00;
			rd_addr_r <= 10'h000;
			rd_sh_r   <= 16'h0000;
			rd_left_r <= 5'h00;
			rd_bit_r  <= 1'b0;
			rd_act_r  <= 1'b0;
			lk_act_r  <= 1'b0;
		end else begin
			lst_r     <= lst_nxt;
			bcnt_r    <= bcnt_nxt;
			rd_addr_r <= rd_addr_nxt;
			rd_sh_r   <= rd_sh_nxt;
			rd_left_r <= rd_left_nxt;
			rd_bit_r  <= rd_bit_nxt;
			rd_act_r  <= rd_act_nxt;
			lk_act_r  <= lk_act_nxt;
		end
	end

	// command registers outlive the frame so the core can take them after deselect
	always_ff @(posedge serial_clock_in or posedge reset) begin
		if (reset) begin
			op_r    <= 2'h0;
			addr_r  <= 11'h000;
			data_r  <= 16'h0000;
			armed_r <= 1'b0;
		end else begin
			op_r    <= op_nxt;
			addr_r  <= addr_nxt;
			data_r  <= data_nxt;
			armed_r <= armed_nxt;
		end
	end

	// ************************************************************
	// core domain: crossing, command take-over, program timer
	// ************************************************************
	logic          sel_s, org_s, armed_s, lk_act_s, rd_act_s, rd_bit_s; // synchronised levels
	logic          sel_d_r, armed_d_r, fresh_r, fresh_nxt;           // edge history
	logic          wen_r, wen_nxt;                                    // programming allowed
	logic          busy_nxt, org_nxt;                                 // busy, organization
	logic          stat_r, stat_nxt;                                  // status shown on select
	logic [CW-1:0] pcnt_r, pcnt_nxt;                                  // cycles left in program
	logic [9:0]    sweep_r, sweep_nxt;                                // byte being visited
	logic          sweep_on_r, sweep_on_nxt;                          // sweep in progress
	logic          pall_r, pall_nxt;                                  // whole-array operation
	logic [15:0]   pdata_r, pdata_nxt;                                // word to store
	logic [9:0]    paddr_r, paddr_nxt;                                // target location
	logic          take, prog_go, hit;                                // decode strobes
	logic          mw_en;                                             // array write this cycle
	logic [7:0]    mw_data;                                           // byte written
	logic          dout_nxt, oe_nxt;                                  // pin next values

	level_sync #(.W(6)) u_sync_core (
		.clk   (clk),
		.clear (reset),
		.d     ({serial_select_in, org_strap_in, armed_r, lk_act_r, rd_act_r, rd_bit_r}),
		.q     ({sel_s, org_s, armed_s, lk_act_s, rd_act_s, rd_bit_s})
	);

	// command taken on the falling select, once per armed command, never while busy
	assign take    = sel_d_r && !sel_s && fresh_r && !busy_r;
	assign prog_go = take && wen_r && (op_r == eeprom_cmd_pkg::OP_WRITE ||
	                 op_r == eeprom_cmd_pkg::OP_ERASE ||
	                 (op_r == eeprom_cmd_pkg::OP_SPECIAL &&
	                  (addr_r[10:9] == eeprom_cmd_pkg::SUB_WRITE_ALL ||
	                   addr_r[10:9] == eeprom_cmd_pkg::SUB_CLEAR_ALL) && !org_r) ||
	                 (op_r == eeprom_cmd_pkg::OP_SPECIAL &&
	                  (addr_r[9:8] == eeprom_cmd_pkg::SUB_WRITE_ALL ||
	                   addr_r[9:8] == eeprom_cmd_pkg::SUB_CLEAR_ALL) && org_r));

	// sweep visits every byte; single-location commands write only their bytes
	assign hit     = pall_r || (org_r ? (sweep_r[9:1] == paddr_r[8:0]) : (sweep_r == paddr_r));
	assign mw_en   = busy_r && sweep_on_r && hit;
	assign mw_data = (org_r && !sweep_r[0]) ? pdata_r[15:8] : pdata_r[7:0];

	// ************************************************************
	// core next state
	// ************************************************************
	always_comb begin
		logic [1:0] csub; // top address bits of the taken command
		csub         = org_r ? addr_r[9:8] : addr_r[10:9];
		fresh_nxt    = fresh_r;
		wen_nxt      = wen_r;
		busy_nxt     = busy_r;
		org_nxt      = org_s; // static strap, followed after reset
		stat_nxt     = stat_r;
		pcnt_nxt     = pcnt_r;
		sweep_nxt    = sweep_r;
		sweep_on_nxt = sweep_on_r;
		pall_nxt     = pall_r;
		pdata_nxt    = pdata_r;
		paddr_nxt    = paddr_r;
		if (!armed_s) begin
			fresh_nxt = 1'b0;
		end else if (!armed_d_r) begin
			fresh_nxt = 1'b1;
		end
		// any deselect uses up the command, so one refused while busy never runs later
		if (sel_d_r && !sel_s) begin
			fresh_nxt = 1'b0;
		end
		if (take && op_r == eeprom_cmd_pkg::OP_SPECIAL) begin
			if (csub == eeprom_cmd_pkg::SUB_ENABLE) begin
				wen_nxt = 1'b1;
			end else if (csub == eeprom_cmd_pkg::SUB_DISABLE) begin
				wen_nxt = 1'b0;
			end
		end
		// a start bit after the cycle returns the output to high impedance
		if (lk_act_s) begin
			stat_nxt = 1'b0;
		end
		if (busy_r) begin
			sweep_nxt = sweep_r + 10'd1;
			if (sweep_r == 10'(eeprom_cmd_pkg::MEM_BYTES - 1)) begin
				sweep_on_nxt = 1'b0;
			end
			pcnt_nxt = pcnt_r - CW'(1);
			if (pcnt_r == '0) begin
				busy_nxt = 1'b0; // ready inside the program cycle time
			end
		end
		if (prog_go) begin
			busy_nxt     = 1'b1;
			stat_nxt     = 1'b1; // set wins over the clear above
			pcnt_nxt     = CW'(PROG_CYCLES - 1);
			sweep_nxt    = 10'h000;
			sweep_on_nxt = 1'b1;
			pall_nxt     = (op_r == eeprom_cmd_pkg::OP_SPECIAL);
			paddr_nxt    = org_r ? {1'b0, addr_r[8:0]} : addr_r[9:0];
			pdata_nxt    = (op_r == eeprom_cmd_pkg::OP_ERASE ||
			                (op_r == eeprom_cmd_pkg::OP_SPECIAL &&
			                 csub == eeprom_cmd_pkg::SUB_CLEAR_ALL))
			               ? {eeprom_cmd_pkg::ERASED_BYTE, eeprom_cmd_pkg::ERASED_BYTE}
			               : data_r;
		end
		// output pin: read data, then busy/ready status, else released
		oe_nxt   = 1'b0;
		dout_nxt = 1'b0;
		if (sel_s && rd_act_s) begin
			oe_nxt   = 1'b1;
			dout_nxt = rd_bit_s;
		end else if (sel_s && stat_r && !lk_act_s) begin
			oe_nxt   = 1'b1;
			dout_nxt = !busy_r; // low while busy, high when ready
		end
	end

	// core registers; the enable starts cleared after power-up
	always_ff @(posedge clk) begin
		if (reset) begin
			sel_d_r         <= 1'b0;
			armed_d_r       <= 1'b0;
			fresh_r         <= 1'b0;
			wen_r           <= 1'b0;
			busy_r          <= 1'b0;
			org_r           <= eeprom_cmd_pkg::ORG_RESET;
			stat_r          <= 1'b0;
			pcnt_r          <= '0;
			sweep_r         <= 10'h000;
			sweep_on_r      <= 1'b0;
			pall_r          <= 1'b0;
			pdata_r         <= 16'h0000;
			paddr_r         <= 10'h000;
			serial_data_out <= 1'b0;
			serial_data_oe  <= 1'b0;
		end else begin
			sel_d_r         <= sel_s;
			armed_d_r       <= armed_s;
			fresh_r         <= fresh_nxt;
			wen_r           <= wen_nxt;
			busy_r          <= busy_nxt;
			org_r           <= org_nxt;
			stat_r          <= stat_nxt;
			pcnt_r          <= pcnt_nxt;
			sweep_r         <= sweep_nxt;
			sweep_on_r      <= sweep_on_nxt;
			pall_r          <= pall_nxt;
			pdata_r         <= pdata_nxt;
			paddr_r         <= paddr_nxt;
			serial_data_out <= dout_nxt;
			serial_data_oe  <= oe_nxt;
		end
	end

	// array write port; no reset, contents are nonvolatile
	always_ff @(posedge clk) begin
		if (mw_en) begin
			mem_r[sweep_r] <= mw_data;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_wen_after_reset: assert property (@(posedge clk) $fell(reset) |-> !wen_r)
		else $error("programming enabled straight after reset");
	a_write_needs_en: assert property (@(posedge clk) disable iff (reset)
		$rose(busy_r) |-> $past(wen_r) && $past(take))
		else $error("program cycle started while disabled");
	a_cycle_bounded: assert property (@(posedge clk) disable iff (reset)
		busy_r |-> pcnt_r <= CW'(PROG_CYCLES - 1))
		else $error("program counter beyond cycle length");
	a_busy_ignores: assert property (@(posedge clk) disable iff (reset)
		busy_r && pcnt_r != '0 |=> busy_r && pcnt_r == $past(pcnt_r) - CW'(1))
		else $error("program cycle disturbed while busy");
	a_status_low: assert property (@(posedge clk) disable iff (reset)
		sel_s && !rd_act_s && stat_r && !lk_act_s && busy_r
		|=> serial_data_oe && !serial_data_out)
		else $error("busy status not driven low");
	a_erase_ones: assert property (@(posedge clk) disable iff (reset)
		prog_go && op_r == eeprom_cmd_pkg::OP_ERASE |=> pdata_r == 16'hFFFF)
		else $error("clear does not store ones");
	a_fill_all: assert property (@(posedge clk) disable iff (reset)
		busy_r && sweep_on_r && pall_r |=> mem_r[$past(sweep_r)] ==
			(($past(sweep_r[0]) || !org_r) ? pdata_r[7:0] : pdata_r[15:8]))
		else $error("whole-array sweep skipped a byte");
	a_read_dummy: assert property (@(posedge serial_clock_in) disable iff (frame_clr)
		lst_r == eeprom_cmd_pkg::L_SHIFT && lst_nxt == eeprom_cmd_pkg::L_READ
		|=> rd_act_r && !rd_bit_r)
		else $error("read did not begin with a dummy zero");
	a_idle_zeros: assert property (@(posedge serial_clock_in) disable iff (frame_clr)
		lst_r == eeprom_cmd_pkg::L_IDLE && !serial_data_in
		|=> lst_r == eeprom_cmd_pkg::L_IDLE)
		else $error("zero bit taken as a start bit");

endmodule : eeprom_cmd_port

// [eeprom_host.sv]
// host side model of the three-wire link: framing, status polling, capture
`timescale 1ns/1ps

module eeprom_host (
	input  wire logic clk,              // core clock, paces the host bits
	output logic      serial_clock_in,  // link clock, still between frames
	output logic      serial_select_in, // device select
	output logic      serial_data_in,   // bits to the device
	input  wire logic serial_data_out,  // bits from the device
	input  wire logic serial_data_oe    // device drives the output
);
	logic [31:0] cap; // every sampled output bit, newest in bit 0
	initial begin
		serial_clock_in = 1'b0;
		serial_select_in = 1'b0;
		serial_data_in = 1'b0;
		cap = 32'h0;
	end
	// data set at a core edge, one link pulse well after it, output sampled late
	task automatic bit_out(input logic b);
		@(posedge clk) serial_data_in <= b;
		#4.3 serial_clock_in = 1'b1;
		#3 serial_clock_in = 1'b0;
		repeat (49) @(posedge clk); // 50 core clocks a bit keeps 2000 kHz at most
		cap = {cap[30:0], serial_data_oe ? serial_data_out : ~serial_data_out}; // released: inverse
	endtask : bit_out
	// one instruction of n bits msb first, then m clocks for read data
	task automatic frame(input logic [31:0] v, input int n, input int m);
		@(posedge clk) serial_select_in <= 1'b1;
		for (int i = n - 1; i >= 0; i--) bit_out(v[i]);
		for (int i = 0; i < m; i++) bit_out(~serial_data_in); // released: flips
		@(posedge clk) serial_select_in <= 1'b0;
		repeat (26) @(posedge clk); // select_low_gap of 0.25 us
	endtask : frame
	// select and look at status until driven high, bounded
	task automatic poll(output int k);
		k = 0;
		do begin
			@(posedge clk) serial_select_in <= 1'b1;
			repeat (6) @(posedge clk);
			cap = {cap[30:0], serial_data_out && serial_data_oe};
			@(posedge clk) serial_select_in <= 1'b0;
			repeat (26) @(posedge clk); // gap again
			k++;
		end while (cap[0] !== 1'b1 && k < 200);
	endtask : poll
endmodule : eeprom_host

// [serial_eeprom_command_port_tb.sv]
// self-checking bench for the command port, host model on the link
`timescale 1ns/1ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("FAIL t=%0t got %0h exp %0h", $time, a, b); end end

module serial_eeprom_command_port_tb;
	localparam int PROG = 2000; // shortened program cycle
	logic        clk, reset, org, sck, cs, di, dout, doe; // bench wires
	int          num_errors = 0, tests_run = 0, n;        // counters
	logic [31:0] seed = 32'h01076124, r;                  // xorshift state
	logic [15:0] w1, w2;                                  // random words
	logic [10:0] a1, a2;                                  // random addresses
	eeprom_cmd_port #(.PROG_CYCLES(PROG)) dut (.clk(clk), .reset(reset),
		.serial_clock_in(sck), .serial_select_in(cs), .serial_data_in(di),
		.org_strap_in(org), .serial_data_out(dout), .serial_data_oe(doe));
	eeprom_host host (.clk(clk), .serial_clock_in(sck), .serial_select_in(cs),
		.serial_data_in(di), .serial_data_out(dout), .serial_data_oe(doe));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// special command address: sub code in the two leading bits
	function automatic logic [10:0] sa(input logic [1:0] s);
		logic [31:0] q;
		q = rnd();
		return org ? {1'b0, s, q[7:0]} : {s, q[8:0]};
	endfunction : sa
	// two leading zeros, start, opcode, address with defined top bit, data
	task automatic cmd(input logic [1:0] op, input logic [10:0] a, input logic [15:0] d,
			input logic hd, input int m);
		logic [31:0] v;
		int          aw;
		int          dw;
		aw = org ? 10 : 11;
		dw = org ? 16 : 8;
		v = (({30'h0, op} | 32'h4) << aw) | ({21'h0, a} & ((32'h1 << aw) - 1));
		if (hd) v = (v << dw) | ({16'h0, d} & ((32'h1 << dw) - 1));
		host.frame(v, 5 + aw + (hd ? dw : 0), m);
	endtask : cmd
	task automatic rd(input logic [10:0] a, input logic [15:0] e);
		cmd(eeprom_cmd_pkg::OP_READ, a, 16'h0, 1'b0, org ? 16 : 8);
		`CHECK(host.cap[org ? 16 : 8], 1'b0)
		`CHECK(host.cap[15:0] & (org ? 16'hFFFF : 16'h00FF), e)
	endtask : rd
	task automatic wt();
		host.poll(n);
		`CHECK(n > 1, 1'b1)
		`CHECK(n <= PROG / 30 + 3, 1'b1)
	endtask : wt
	task automatic end_sim();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		#600000; // about 40k clocks of frames and polling, half again as margin
		num_errors++;
		end_sim();
	end
	initial begin
		reset = 1'b1;
		org = 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (PROG / 5) @(posedge clk); // power-up wait, scaled like the program cycle
		`CHECK(doe, 1'b0)
		r = rnd();
		w1 = r[15:0];
		w2 = r[31:16];
		r = rnd();
		a1 = r[10:0];
		a2 = r[26:16];
		cmd(eeprom_cmd_pkg::OP_SPECIAL, sa(eeprom_cmd_pkg::SUB_ENABLE), 16'h0, 1'b0, 0);
		cmd(eeprom_cmd_pkg::OP_SPECIAL, sa(eeprom_cmd_pkg::SUB_WRITE_ALL), w1, 1'b1, 0);
		cmd(eeprom_cmd_pkg::OP_WRITE, a1, ~w1, 1'b1, 0);
		wt();
		rd(a1, w1);
		cmd(eeprom_cmd_pkg::OP_WRITE, 11'h1FF, w2, 1'b1, 0);
		wt();
		cmd(eeprom_cmd_pkg::OP_WRITE, 11'h000, ~w2, 1'b1, 0);
		wt();
		cmd(eeprom_cmd_pkg::OP_READ, 11'h3FF, 16'h0, 1'b0, 32);
		`CHECK(host.cap, {w2, ~w2})
		cmd(eeprom_cmd_pkg::OP_ERASE, 11'h3FF, 16'h0, 1'b0, 0);
		wt();
		rd(11'h1FF, 16'hFFFF);
		rd(11'h000, ~w2);
		cmd(eeprom_cmd_pkg::OP_SPECIAL, sa(eeprom_cmd_pkg::SUB_DISABLE), 16'h0, 1'b0, 0);
		cmd(eeprom_cmd_pkg::OP_WRITE, 11'h000, w1, 1'b1, 0);
		rd(11'h000, ~w2);
		cmd(eeprom_cmd_pkg::OP_SPECIAL, sa(eeprom_cmd_pkg::SUB_ENABLE), 16'h0, 1'b0, 0);
		cmd(eeprom_cmd_pkg::OP_SPECIAL, sa(eeprom_cmd_pkg::SUB_CLEAR_ALL), 16'h0, 1'b0, 0);
		wt();
		rd(a1, 16'hFFFF);
		reset <= 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (PROG / 5) @(posedge clk); // power-up wait again
		`CHECK(doe, 1'b0)
		cmd(eeprom_cmd_pkg::OP_WRITE, a1, w2, 1'b1, 0);
		rd(a1, 16'hFFFF);
		org <= 1'b0;
		repeat (6) @(posedge clk);
		cmd(eeprom_cmd_pkg::OP_SPECIAL, sa(eeprom_cmd_pkg::SUB_ENABLE), 16'h0, 1'b0, 0);
		cmd(eeprom_cmd_pkg::OP_WRITE, a2, w2, 1'b1, 0);
		wt();
		rd(a2, {8'h00, w2[7:0]});
		end_sim();
	end
endmodule : serial_eeprom_command_port_tb
